// ==== ptp_pkg.sv ====
// Purpose: shared constants and types of the prescaled period timer
// Assumes: 32-bit AXI4-Lite register window, 8-bit registers in low bits
// Notes:   offsets are byte addresses, one aligned word each
package ptp_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          REG_W       = 8;

    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_COUNT   = 8'h04;
    localparam logic [7:0]  OFF_LIMIT   = 8'h08;
    localparam logic [7:0]  OFF_FLAGS   = 8'h0C;
    localparam logic [7:0]  OFF_ENABLES = 8'h10;
    localparam logic [7:0]  OFF_PRIOS   = 8'h14;

    localparam logic [7:0]  COUNT_RST   = 8'h00;
    localparam logic [7:0]  LIMIT_RST   = 8'hFF;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;
    localparam logic [7:0]  COUNT_STEP  = 8'h01;

    // match flag, enable and priority share this position in their registers
    localparam int          MATCH_BIT   = 1;

    // instruction rate is the system clock divided by this
    localparam int          QUARTER_DIV = 4;
    localparam logic [1:0]  QUARTER_END = 2'(QUARTER_DIV - 1);

    localparam logic [1:0]  PS_DIV1     = 2'h0;
    localparam logic [1:0]  PS_DIV4     = 2'h1;
    localparam logic [1:0]  PS4_END     = 2'h3;
    localparam logic [3:0]  PS16_END    = 4'hF;
    localparam int          PS_HI_BIT   = 1;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       unused;
        logic [3:0] postscale;
        logic       run;
        logic [1:0] prescale;
    } ptp_ctrl_s;

    typedef enum {
        REG_CTRL,
        REG_COUNT,
        REG_LIMIT,
        REG_FLAGS,
        REG_ENABLES,
        REG_PRIOS,
        REG_NONE
    } ptp_reg_e;
endpackage

// ==== ptp_prescaler.sv ====
// Purpose: quarter-rate divider and 1/4/16 input prescaler
// Assumes: clear is a one-cycle pulse from register writes
// Notes:   tick is combinational, one aclk wide
`timescale 1ns/10ps
module ptp_prescaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [1:0] select,
    input  wire logic       clear,
    output logic            tick
);
    logic [1:0] quarter;
    logic [1:0] next_quarter;
    logic [3:0] pre;
    logic [3:0] next_pre;
    logic       instr_tick;

    always_comb begin
        instr_tick   = run && (quarter == ptp_pkg::QUARTER_END);
        next_quarter = run ? quarter + 2'h1 : quarter;
        next_pre     = pre;
        if (clear) begin
            next_pre = 4'h0;
        end else if (instr_tick) begin
            next_pre = pre + 4'h1;
        end
        if (select == ptp_pkg::PS_DIV1) begin
            tick = instr_tick;
        end else if (select == ptp_pkg::PS_DIV4) begin
            tick = instr_tick && (pre[1:0] == ptp_pkg::PS4_END);
        end else begin
            tick = instr_tick && (pre == ptp_pkg::PS16_END);
        end
        if (clear) begin
            tick = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quarter <= 2'h0;
            pre     <= 4'h0;
        end else begin
            quarter <= next_quarter;
            pre     <= next_pre;
        end
    end
endmodule

// ==== ptp_postscaler.sv ====
// Purpose: 1 to 16 postscaler counting period matches
// Assumes: match is a one-cycle pulse
// Notes:   event is combinational, one aclk wide
`timescale 1ns/10ps
module ptp_postscaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       match,
    input  wire logic [3:0] ratio,
    input  wire logic       clear,
    output logic            event_out
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    always_comb begin
        event_out = match && !clear && (cnt == ratio);
        next_cnt  = cnt;
        if (clear) begin
            next_cnt = 4'h0;
        end else if (event_out) begin
            next_cnt = 4'h0;
        end else if (match) begin
            next_cnt = cnt + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 4'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// ==== ptp_timer.sv ====
// Purpose: 8-bit prescaled period timer with AXI4-Lite registers
// Assumes: aclk is the oscillator clock; instruction rate is a quarter of it
// Notes:   registers are 8 bits in the low byte of each word
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ptp_timer (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [ptp_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [ptp_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ptp_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [ptp_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic                             pwm_time_base,
    output logic                             serial_shift_clk,
    output logic                             irq_req,
    output logic                             irq_priority
);
    localparam int RW = ptp_pkg::REG_W;

    function automatic ptp_pkg::ptp_reg_e decode(input logic [ptp_pkg::ADDR_W-1:0] addr);
        case (addr)
            ptp_pkg::OFF_CTRL:    decode = ptp_pkg::REG_CTRL;
            ptp_pkg::OFF_COUNT:   decode = ptp_pkg::REG_COUNT;
            ptp_pkg::OFF_LIMIT:   decode = ptp_pkg::REG_LIMIT;
            ptp_pkg::OFF_FLAGS:   decode = ptp_pkg::REG_FLAGS;
            ptp_pkg::OFF_ENABLES: decode = ptp_pkg::REG_ENABLES;
            ptp_pkg::OFF_PRIOS:   decode = ptp_pkg::REG_PRIOS;
            default:              decode = ptp_pkg::REG_NONE;
        endcase
    endfunction

    // bus state
    logic                       aw_full;
    logic                       next_aw_full;
    logic [ptp_pkg::ADDR_W-1:0] aw_addr;
    logic [ptp_pkg::ADDR_W-1:0] next_aw_addr;
    logic                       w_full;
    logic                       next_w_full;
    logic [RW-1:0]              w_data;
    logic [RW-1:0]              next_w_data;
    logic                       w_lane;
    logic                       next_w_lane;
    logic                       next_awready;
    logic                       next_wready;
    logic [1:0]                 next_bresp;
    logic                       next_bvalid;
    logic                       next_arready;
    logic [ptp_pkg::DATA_W-1:0] next_rdata;
    logic [1:0]                 next_rresp;
    logic                       next_rvalid;

    // timer state
    ptp_pkg::ptp_ctrl_s         ctrl;
    ptp_pkg::ptp_ctrl_s         next_ctrl;
    logic [RW-1:0]              count;
    logic [RW-1:0]              next_count;
    logic [RW-1:0]              limit;
    logic [RW-1:0]              next_limit;
    logic                       flag;
    logic                       next_flag;
    logic                       enable;
    logic                       next_enable;
    logic                       prio;
    logic                       next_prio;
    logic                       next_pwm;
    logic                       next_shift;
    logic                       next_irq;

    // decoded strobes
    logic                       wr_go;
    logic                       wr_en;
    ptp_pkg::ptp_reg_e          wr_reg;
    ptp_pkg::ptp_reg_e          rd_reg;
    logic                       scaler_clear;
    logic                       tick;
    logic                       hit;
    logic                       post_evt;

    ptp_prescaler u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (ctrl.run),
        .select  (ctrl.prescale),
        .clear   (scaler_clear),
        .tick    (tick)
    );

    ptp_postscaler u_post (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .match     (hit),
        .ratio     (ctrl.postscale),
        .clear     (scaler_clear),
        .event_out (post_evt)
    );

    // write channel: address and data taken in either order
    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full  = w_full;
        next_w_data  = w_data;
        next_w_lane  = w_lane;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        wr_go        = aw_full && w_full && !s_axi_bvalid;
        wr_reg       = decode(aw_addr);
        wr_en        = wr_go && w_lane;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata[RW-1:0];
            next_w_lane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_reg == ptp_pkg::REG_NONE) ?
                           ptp_pkg::RESP_SLVERR : ptp_pkg::RESP_OKAY;
        end
        next_awready = !next_aw_full;
        next_wready  = !next_w_full;
    end

    // read channel: one outstanding read
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        rd_reg      = decode(s_axi_araddr);
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = ptp_pkg::RESP_OKAY;
            next_rdata  = '0;
            case (rd_reg)
                ptp_pkg::REG_CTRL: begin
                    next_rdata[RW-1:0] = {1'b0, ctrl[RW-2:0]};
                end
                ptp_pkg::REG_COUNT: begin
                    next_rdata[RW-1:0] = count;
                end
                ptp_pkg::REG_LIMIT: begin
                    next_rdata[RW-1:0] = limit;
                end
                ptp_pkg::REG_FLAGS: begin
                    next_rdata[ptp_pkg::MATCH_BIT] = flag;
                end
                ptp_pkg::REG_ENABLES: begin
                    next_rdata[ptp_pkg::MATCH_BIT] = enable;
                end
                ptp_pkg::REG_PRIOS: begin
                    next_rdata[ptp_pkg::MATCH_BIT] = prio;
                end
                default: begin
                    next_rresp = ptp_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // timer core
    always_comb begin
        next_ctrl   = ctrl;
        next_limit  = limit;
        next_enable = enable;
        next_prio   = prio;
        next_count  = count;
        next_flag   = flag;
        next_shift  = serial_shift_clk;
        scaler_clear = wr_en && (wr_reg == ptp_pkg::REG_CTRL || wr_reg == ptp_pkg::REG_COUNT);
        hit = tick && !scaler_clear && (count == limit);
        next_pwm = hit;
        if (hit) begin
            next_shift = !serial_shift_clk;
        end
        if (wr_en && wr_reg == ptp_pkg::REG_CTRL) begin
            next_ctrl = ptp_pkg::ptp_ctrl_s'(w_data);
            next_ctrl.unused = 1'b0;
        end
        if (wr_en && wr_reg == ptp_pkg::REG_LIMIT) begin
            next_limit = w_data;
        end
        if (wr_en && wr_reg == ptp_pkg::REG_ENABLES) begin
            next_enable = w_data[ptp_pkg::MATCH_BIT];
        end
        if (wr_en && wr_reg == ptp_pkg::REG_PRIOS) begin
            next_prio = w_data[ptp_pkg::MATCH_BIT];
        end
        if (wr_en && wr_reg == ptp_pkg::REG_COUNT) begin
            next_count = w_data;
        end else if (hit) begin
            next_count = ptp_pkg::ZERO_BYTE;
        end else if (tick) begin
            next_count = count + ptp_pkg::COUNT_STEP;
        end
        if (wr_en && wr_reg == ptp_pkg::REG_FLAGS) begin
            next_flag = w_data[ptp_pkg::MATCH_BIT];
        end
        if (post_evt) begin
            next_flag = 1'b1;
        end
        next_irq = next_flag && next_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            aw_addr       <= '0;
            w_full        <= 1'b0;
            w_data        <= '0;
            w_lane        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bresp   <= ptp_pkg::RESP_OKAY;
            s_axi_bvalid  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= ptp_pkg::RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
        end else begin
            aw_full       <= next_aw_full;
            aw_addr       <= next_aw_addr;
            w_full        <= next_w_full;
            w_data        <= next_w_data;
            w_lane        <= next_w_lane;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bresp   <= next_bresp;
            s_axi_bvalid  <= next_bvalid;
            s_axi_arready <= next_arready;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            s_axi_rvalid  <= next_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl             <= ptp_pkg::ptp_ctrl_s'(ptp_pkg::CTRL_RST);
            count            <= ptp_pkg::COUNT_RST;
            limit            <= ptp_pkg::LIMIT_RST;
            flag             <= 1'b0;
            enable           <= 1'b0;
            prio             <= 1'b0;
            pwm_time_base    <= 1'b0;
            serial_shift_clk <= 1'b0;
            irq_req          <= 1'b0;
            irq_priority     <= 1'b0;
        end else begin
            ctrl             <= next_ctrl;
            count            <= next_count;
            limit            <= next_limit;
            flag             <= next_flag;
            enable           <= next_enable;
            prio             <= next_prio;
            pwm_time_base    <= next_pwm;
            serial_shift_clk <= next_shift;
            irq_req          <= next_irq;
            irq_priority     <= next_prio;
        end
    end
endmodule

// ==== ptp_timer_props.sv ====
// Purpose: port-level checks of the prescaled period timer
// Assumes: bound to ptp_timer, one clock domain
// Notes:   match spacing relies on the quarter-rate tick
`timescale 1ns/10ps
module ptp_timer_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pwm_time_base,
    input wire logic        serial_shift_clk
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered in time");
    a_aw_taken: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready stayed high");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered in time");
    a_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while answer pending");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_match_pulse: assert property (
        pwm_time_base |=> !pwm_time_base [*3])
        else $error("match pulse too long or too close");
    a_shift_cause: assert property (
        $changed(serial_shift_clk) |-> pwm_time_base || $past(pwm_time_base))
        else $error("shift clock moved without a match");
endmodule

// ==== ptp_timer_tb_top.sv ====
// Purpose: self-checking bench of the prescaled period timer
// Assumes: register offsets and response codes of ptp_pkg
// Notes:   all traffic goes through the register bus tasks
`timescale 1ns/10ps
module ptp_timer_tb_top;
    localparam logic [1:0] OK = ptp_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ptp_pkg::RESP_SLVERR;
    localparam logic [7:0] CTRL = ptp_pkg::OFF_CTRL;
    localparam logic [7:0] CNT = ptp_pkg::OFF_COUNT;
    localparam logic [7:0] LIM = ptp_pkg::OFF_LIMIT;
    localparam logic [7:0] FLG = ptp_pkg::OFF_FLAGS;
    localparam logic [7:0] ENA = ptp_pkg::OFF_ENABLES;
    localparam logic [7:0] PRI = ptp_pkg::OFF_PRIOS;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        pwm_time_base;
    logic        serial_shift_clk;
    logic        irq_req;
    logic        irq_priority;
    logic [7:0]  last_rd;
    logic [7:0]  c1;
    int          num_errors = 0;
    int          n_tests = 0;
    // lazy: response ready raised only once the answer is seen
    bit          lazy = 1'b0;

    ptp_timer dut_u (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic hang();
        num_errors++;
        $display("BAD t=%0t wait ran out", $time);
        end_of_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = OK);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !lazy;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (i == 100) hang();
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er = OK,
                      input bit cd = 1'b1);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !lazy;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (i == 100) hang();
        last_rd = s_axi_rdata[7:0];
        chk(32'(s_axi_rresp), 32'(er));
        if (cd) chk(s_axi_rdata, {24'h000000, ed});
    endtask

    // cycles between two matches and one shift clock toggle per match
    task automatic gap(input int exp_n);
        int i;
        int n;
        logic s1;
        for (i = 0; i < 3000 && pwm_time_base !== 1'b1; i++) @(posedge aclk);
        @(posedge aclk);
        s1 = serial_shift_clk;
        for (n = 1; n < 3000 && pwm_time_base !== 1'b1; n++) @(posedge aclk);
        @(posedge aclk);
        if (i == 3000 || n == 3000) hang();
        chk(32'(n), 32'(exp_n));
        chk(32'(serial_shift_clk), 32'(!s1));
    endtask

    // matches counted until the request rises; mid restarts via a count write
    task automatic ps_run(input logic [3:0] n, input bit mid);
        int i;
        int k;
        wr(CTRL, 8'h00);
        wr(CNT, 8'h00);
        wr(FLG, 8'h00);
        wr(CTRL, {1'b0, n, 1'b1, 2'h1});
        k = 0;
        for (i = 0; i < 3000 && irq_req !== 1'b1; i++) begin
            @(posedge aclk);
            if (pwm_time_base === 1'b1) k++;
            if (mid && k == 1) begin
                wr(CNT, 8'h00);
                k = 0;
                mid = 1'b0;
            end
        end
        if (i == 3000) hang();
        chk(32'(k), 32'(n) + 32'h1);
        rd(FLG, 8'h02);
    endtask

    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL, 8'h00);
        rd(CNT, 8'h00);
        rd(LIM, 8'hFF);
        rd(FLG, 8'h00);
        wr(CTRL, 8'hF8);
        rd(CTRL, 8'h78);
        wr(8'h20, 8'h11, ERR);
        rd(8'h20, 8'h00, ERR);
        wr(LIM, 8'h5A);
        rd(LIM, 8'h5A);
        lazy = 1'b1;
        s_axi_wstrb <= 4'hE;
        wr(LIM, 8'h77);
        s_axi_wstrb <= 4'hF;
        rd(LIM, 8'h5A);
        lazy = 1'b0;
        wr(CNT, 8'h00);
        wr(CTRL, 8'h04);
        repeat (60) @(posedge aclk);
        wr(CTRL, 8'h08);
        rd(CNT, 8'h00, OK, 1'b0);
        c1 = last_rd;
        chk(32'(c1 === 8'h00), 32'h0);
        repeat (50) @(posedge aclk);
        rd(CNT, c1);
        wr(CTRL, 8'h01);
        rd(CNT, c1);
        wr(CNT, 8'h33);
        rd(CNT, 8'h33);
        wr(LIM, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(CTRL, 8'h00);
            wr(CNT, 8'h00);
            wr(CTRL, {5'h00, 1'b1, 2'(c)});
            gap(3 * ptp_pkg::QUARTER_DIV * (c == 0 ? 1 : (c == 1 ? 4 : 16)));
        end
        wr(LIM, 8'h00);
        wr(ENA, 8'h02);
        rd(ENA, 8'h02);
        ps_run(4'h0, 1'b0);
        ps_run(4'h3, 1'b0);
        ps_run(4'hF, 1'b0);
        ps_run(4'h1, 1'b1);
        chk(32'(irq_req), 32'h1);
        wr(CTRL, 8'h00);
        repeat (40) @(posedge aclk);
        rd(FLG, 8'h02);
        chk(32'(irq_req), 32'h1);
        wr(FLG, 8'h00);
        rd(FLG, 8'h00);
        chk(32'(irq_req), 32'h0);
        wr(ENA, 8'h00);
        wr(CTRL, 8'h05);
        repeat (40) @(posedge aclk);
        rd(FLG, 8'h02);
        chk(32'(irq_req), 32'h0);
        wr(ENA, 8'h02);
        rd(ENA, 8'h02);
        chk(32'(irq_req), 32'h1);
        chk(32'(irq_priority), 32'h0);
        wr(PRI, 8'h02);
        rd(PRI, 8'h02);
        chk(32'(irq_priority), 32'h1);
        wr(PRI, 8'h00);
        chk(32'(irq_priority), 32'h0);
        end_of_test();
    end
endmodule

bind ptp_timer ptp_timer_props u_props (.*);
